//--- conv_model.sv
`timescale 1ns/10ps
`default_nettype none
module conv_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [2:0] chan_i,
  input wire logic [2:0] ovf_chan_i,
  input wire logic slow_i,
  output logic done_o,
  output logic ovf_o
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] chan_q = 3'h0;
  logic busy = 1'b0;
  logic last = 1'b0;
  initial begin
    done_o = 1'b0;
    ovf_o = 1'b0;
  end
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    // overflow only means something with done, so show a stale inverse
    ovf_o <= ~last;
    if (start_i) begin
      busy <= 1'b1;
      cnt <= slow_i ? 3'h5 : 3'h1;
      chan_q <= chan_i;
    end else if (busy) begin
      if (cnt == 3'h0) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        ovf_o <= (chan_q == ovf_chan_i);
        last <= (chan_q == ovf_chan_i);
      end else begin
        cnt <= cnt - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sensor_command_response_mailbox.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1 - interval high byte forms bits 15:8
// R2 - wake spacing is interval times 31.25 ms
// R3 - each wake runs every enabled channel; code ignores a wake that arrives while the sequencer is outside ST_IDLE
// R4 - early revision swaps interval byte addresses; code moves low byte to 0x0A and high byte to 0x08
// R5 - led pair bits 7:4 drive second LED
// R6 - led pair bits 3:0 drive first LED
// R7 - code zero disables, higher codes more current
// R8 - host zeroes second LED on single-LED parts
// R9 - third LED register bits 3:0, rest reserved
// R10 - parameter mailbox feeds the sequencer
// R11 - command write hands code to sequencer
// R12 - only a command write leaves standby; code also leaves standby on a wake
// R13 - errors load codes with top bit set
// R14 - error held until reset or no-op
// R15 - other commands ignored while error held
// R16 - errors never stop autonomous measurement
// R17 - no error: low nibble counts completed commands
// R18 - host polls counter, not a fixed delay
// R19 - unknown command reports code 0x80
// R20 - proximity overflows report 0x88 to 0x8A
// R21 - light and auxiliary overflows report 0x8C to 0x8E
// R22 - host writes unlock key before use
// R23 - enabled command flag raises interrupt output
// R24 - reserved third LED bits read zero
module sensor_command_response_mailbox #(
  parameter int WAKE_UNIT_CYCLES = sensor_mailbox_pkg::WAKE_UNIT_CYCLES,
  // arbitrary value
  parameter logic [7:0] EARLY_REVISION = 8'h5A
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] sequencer_revision_i,
  input wire logic [5:0] enabled_channel_list_i,
  input wire logic cmd_irq_enable_i,
  input wire logic cmd_flag_clear_i,
  input wire logic meas_done_i,
  input wire logic meas_overflow_i,
  output logic meas_start_o,
  output sensor_mailbox_pkg::meas_req_s meas_req_o,
  output logic [2:0] led_sink_en_o,
  output logic [7:0] param_value_o,
  output logic standby_o,
  output logic cmd_flag_o,
  output logic irq_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PICK, ST_WAIT} seq_state_e;

  seq_state_e state_reg;
  logic [7:0] interval_low_reg, interval_high_reg;
  logic [7:0] led_pair_reg;
  logic [3:0] third_led_reg;
  logic [7:0] param_mailbox_reg, command_reg, response_reg;
  logic cmd_pending_reg, auto_run_reg;
  logic [3:0] exec_cnt_reg;
  logic [2:0] chan_reg;
  logic [15:0] wake_interval;
  logic [7:0] low_addr, high_addr;
  logic wake, cmd_write, error_held, take_cmd, clearing_cmd, exec_done;
  logic known_cmd, overflow_hit;
  logic [7:0] overflow_code;
  logic [3:0] led_code [3];

  assign wake_interval = {interval_high_reg, interval_low_reg}; // R1
  assign low_addr = (sequencer_revision_i == EARLY_REVISION) ?
    sensor_mailbox_pkg::ADDR_INTERVAL_LOW_EARLY :
    sensor_mailbox_pkg::ADDR_INTERVAL_LOW; // R4
  assign high_addr = (sequencer_revision_i == EARLY_REVISION) ?
    sensor_mailbox_pkg::ADDR_INTERVAL_HIGH_EARLY :
    sensor_mailbox_pkg::ADDR_INTERVAL_HIGH; // R4
  assign cmd_write = reg_wr_i &&
    reg_addr_i == sensor_mailbox_pkg::ADDR_COMMAND; // R11
  assign error_held = response_reg[sensor_mailbox_pkg::RESP_ERROR_BIT];
  assign clearing_cmd = command_reg == sensor_mailbox_pkg::CMD_NOP ||
    command_reg == sensor_mailbox_pkg::CMD_RESET;
  assign known_cmd = clearing_cmd ||
    command_reg == sensor_mailbox_pkg::CMD_FORCE ||
    command_reg == sensor_mailbox_pkg::CMD_AUTO_STOP ||
    command_reg == sensor_mailbox_pkg::CMD_AUTO_RUN ||
    command_reg == sensor_mailbox_pkg::CMD_PARAM_SET;
  // a measurement in progress delays the command: completion time varies
  assign take_cmd = state_reg == ST_IDLE && !wake && cmd_pending_reg;
  assign exec_done = state_reg == ST_EXEC &&
    exec_cnt_reg == sensor_mailbox_pkg::CMD_EXEC_CYCLES;
  assign overflow_hit = state_reg == ST_WAIT && meas_done_i &&
    meas_overflow_i;
  assign overflow_code = (chan_reg < sensor_mailbox_pkg::PROX_COUNT) ?
    sensor_mailbox_pkg::ERR_PROX_BASE + {5'h00, chan_reg} :
    sensor_mailbox_pkg::ERR_LIGHT_BASE +
    {5'h00, 3'(chan_reg - sensor_mailbox_pkg::PROX_COUNT)}; // R20 R21

  assign led_code[0] = led_pair_reg[sensor_mailbox_pkg::FIRST_LED_LSB +: 4];
  assign led_code[1] =
    led_pair_reg[sensor_mailbox_pkg::SECOND_LED_LSB +: 4]; // R5
  assign led_code[2] = third_led_reg;

  wake_timer #(
    .UNIT_CYCLES(WAKE_UNIT_CYCLES)
  ) u_wake_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(auto_run_reg),
    .interval_i(wake_interval),
    .wake_o(wake)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      interval_low_reg <= sensor_mailbox_pkg::RST_BYTE;
      interval_high_reg <= sensor_mailbox_pkg::RST_BYTE;
      led_pair_reg <= sensor_mailbox_pkg::RST_BYTE;
      third_led_reg <= sensor_mailbox_pkg::RST_NIBBLE;
      param_mailbox_reg <= sensor_mailbox_pkg::RST_BYTE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == low_addr) begin
        interval_low_reg <= reg_wdata_i;
      end
      if (reg_addr_i == high_addr) begin
        interval_high_reg <= reg_wdata_i; // R4
      end
      if (reg_addr_i == sensor_mailbox_pkg::ADDR_LED_PAIR) begin
        led_pair_reg <= reg_wdata_i; // R5 R6
      end
      if (reg_addr_i == sensor_mailbox_pkg::ADDR_THIRD_LED) begin
        third_led_reg <= reg_wdata_i[3:0]; // R9 R24
      end
      if (reg_addr_i == sensor_mailbox_pkg::ADDR_PARAM) begin
        param_mailbox_reg <= reg_wdata_i; // R10
      end
    end
  end

  // a new command write in the take cycle keeps the request pending
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      command_reg <= sensor_mailbox_pkg::RST_BYTE;
      cmd_pending_reg <= 1'b0;
    end else if (cmd_write) begin
      command_reg <= reg_wdata_i; // R11
      cmd_pending_reg <= 1'b1;
    end else if (take_cmd) begin
      cmd_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == low_addr) begin
        reg_rdata_o <= interval_low_reg;
      end else if (reg_addr_i == high_addr) begin
        reg_rdata_o <= interval_high_reg;
      end else if (reg_addr_i == sensor_mailbox_pkg::ADDR_LED_PAIR) begin
        reg_rdata_o <= led_pair_reg;
      end else if (reg_addr_i == sensor_mailbox_pkg::ADDR_THIRD_LED) begin
        reg_rdata_o <= {4'h0, third_led_reg}; // R24
      end else if (reg_addr_i == sensor_mailbox_pkg::ADDR_PARAM) begin
        reg_rdata_o <= param_mailbox_reg;
      end else if (reg_addr_i == sensor_mailbox_pkg::ADDR_COMMAND) begin
        reg_rdata_o <= command_reg;
      end else if (reg_addr_i == sensor_mailbox_pkg::ADDR_RESPONSE) begin
        reg_rdata_o <= response_reg;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // sequencer: command execution and channel walk share one engine
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      exec_cnt_reg <= 4'h0;
      chan_reg <= 3'h0;
      auto_run_reg <= 1'b0;
      param_value_o <= 8'h00;
      meas_start_o <= 1'b0;
      meas_req_o <= '0;
    end else begin
      meas_start_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (wake && enabled_channel_list_i != 6'h00) begin
            chan_reg <= 3'h0;
            state_reg <= ST_PICK; // R3 R16
          end else if (take_cmd && (!error_held || clearing_cmd)) begin
            exec_cnt_reg <= 4'h1;
            state_reg <= ST_EXEC; // R15
          end
        end
        ST_EXEC: begin
          exec_cnt_reg <= exec_cnt_reg + 4'h1;
          if (exec_done) begin
            state_reg <= ST_IDLE;
            if (command_reg == sensor_mailbox_pkg::CMD_RESET ||
                command_reg == sensor_mailbox_pkg::CMD_AUTO_STOP) begin
              auto_run_reg <= 1'b0;
            end
            if (command_reg == sensor_mailbox_pkg::CMD_AUTO_RUN) begin
              auto_run_reg <= 1'b1;
            end
            if (command_reg == sensor_mailbox_pkg::CMD_PARAM_SET) begin
              param_value_o <= param_mailbox_reg; // R10
            end
            if (command_reg == sensor_mailbox_pkg::CMD_FORCE &&
                enabled_channel_list_i != 6'h00) begin
              chan_reg <= 3'h0;
              state_reg <= ST_PICK;
            end
          end
        end
        ST_PICK: begin
          if (enabled_channel_list_i[chan_reg]) begin
            meas_start_o <= 1'b1;
            meas_req_o <= '{chan: chan_reg, first_led: led_code[0],
              second_led: led_code[1], third_led: led_code[2]};
            state_reg <= ST_WAIT;
          end else if (chan_reg == sensor_mailbox_pkg::CHAN_LAST) begin
            state_reg <= ST_IDLE;
          end else begin
            chan_reg <= chan_reg + 3'h1; // R3
          end
        end
        ST_WAIT: begin
          if (meas_done_i) begin
            if (chan_reg == sensor_mailbox_pkg::CHAN_LAST) begin
              state_reg <= ST_IDLE;
            end else begin
              chan_reg <= chan_reg + 3'h1;
              state_reg <= ST_PICK; // R16
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      response_reg <= 8'h00;
    end else if (overflow_hit) begin
      response_reg <= overflow_code; // R13 R20 R21
    end else if (exec_done) begin
      if (clearing_cmd && error_held) begin
        response_reg <= 8'h00; // R14
      end else if (command_reg == sensor_mailbox_pkg::CMD_RESET) begin
        response_reg <= 8'h00; // R14
      end else if (!known_cmd) begin
        response_reg <= sensor_mailbox_pkg::ERR_INVALID; // R19
      end else begin
        response_reg <= {4'h0, response_reg[3:0] + 4'h1}; // R17
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      standby_o <= 1'b1;
    end else if (cmd_write || wake) begin
      standby_o <= 1'b0; // R12
    end else if (state_reg == ST_IDLE && !cmd_pending_reg) begin
      standby_o <= 1'b1;
    end
  end

  // the flag set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (exec_done) begin
        cmd_flag_o <= 1'b1;
      end else if (cmd_flag_clear_i) begin
        cmd_flag_o <= 1'b0;
      end
      irq_o <= cmd_flag_o && cmd_irq_enable_i; // R23
    end
  end

  generate
    for (genvar i = 0; i < sensor_mailbox_pkg::NUM_PROX; i++) begin : g_led
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          led_sink_en_o[i] <= 1'b0;
        end else begin
          led_sink_en_o[i] <= state_reg == ST_WAIT && !meas_done_i &&
            chan_reg < sensor_mailbox_pkg::PROX_COUNT &&
            led_code[i] != 4'h0; // R7
        end
      end
    end
  endgenerate

  a_error_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take_cmd && error_held && !clearing_cmd |=> state_reg == ST_IDLE) // R15
    else $error("command taken while error held");
  a_invalid_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    exec_done && !known_cmd && !overflow_hit |=>
    response_reg == 8'h80) // R19
    else $error("unknown command not reported");
  a_counter_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    exec_done && known_cmd && !error_held && !overflow_hit &&
    command_reg != sensor_mailbox_pkg::CMD_RESET |=>
    response_reg[3:0] == $past(response_reg[3:0]) + 4'h1 &&
    response_reg[7:4] == 4'h0) // R17
    else $error("response counter did not step");
  a_error_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    exec_done && clearing_cmd && error_held && !overflow_hit |=>
    response_reg == 8'h00) // R14
    else $error("error not cleared");
  a_overflow_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    overflow_hit && chan_reg == 3'h4 |=> response_reg == 8'h8D) // R21
    else $error("wrong overflow code");
  a_prox_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    overflow_hit && chan_reg == 3'h2 |=> response_reg == 8'h8A) // R20
    else $error("wrong proximity overflow code");
  a_walk_goes_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    overflow_hit && chan_reg != sensor_mailbox_pkg::CHAN_LAST |=>
    state_reg == ST_PICK) // R16
    else $error("walk stopped on error");
  a_standby_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    standby_o && !cmd_write && !wake |=> standby_o) // R12
    else $error("standby left without command write");
  a_exec_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(state_reg == ST_EXEC) |-> ##3 exec_done) // R11
    else $error("command execution length wrong");
  a_irq_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    exec_done && cmd_irq_enable_i ##1 cmd_irq_enable_i |=> irq_o) // R23
    else $error("interrupt not raised");
  a_led_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    led_code[0] == 4'h0 |=> !led_sink_en_o[0]) // R7
    else $error("disabled sink drove");
endmodule
`default_nettype wire

//--- sensor_mailbox_pkg.sv
package sensor_mailbox_pkg;

  localparam logic [7:0] ADDR_INTERVAL_LOW = 8'h08;
  localparam logic [7:0] ADDR_INTERVAL_HIGH = 8'h09;
  localparam logic [7:0] ADDR_INTERVAL_LOW_EARLY = 8'h0A;
  localparam logic [7:0] ADDR_INTERVAL_HIGH_EARLY = 8'h08;
  localparam logic [7:0] ADDR_LED_PAIR = 8'h0F;
  localparam logic [7:0] ADDR_THIRD_LED = 8'h10;
  localparam logic [7:0] ADDR_PARAM = 8'h17;
  localparam logic [7:0] ADDR_COMMAND = 8'h18;
  localparam logic [7:0] ADDR_RESPONSE = 8'h20;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  localparam int SECOND_LED_LSB = 4;
  localparam int FIRST_LED_LSB = 0;
  localparam int THIRD_LED_LSB = 0;
  localparam int RESP_ERROR_BIT = 7;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h01;
  localparam logic [7:0] CMD_FORCE = 8'h06;
  localparam logic [7:0] CMD_AUTO_STOP = 8'h0B;
  localparam logic [7:0] CMD_AUTO_RUN = 8'h0F;
  localparam logic [7:0] CMD_PARAM_SET = 8'hA0;

  localparam logic [7:0] ERR_INVALID = 8'h80;
  localparam logic [7:0] ERR_PROX_BASE = 8'h88;
  localparam logic [7:0] ERR_LIGHT_BASE = 8'h8C;

  localparam int NUM_CHANNELS = 6;
  localparam int NUM_PROX = 3;
  localparam logic [2:0] CHAN_LAST = 3'h5;
  localparam logic [2:0] PROX_COUNT = 3'h3;

  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_UNIT_NS = 31_250_000;
  localparam int WAKE_UNIT_CYCLES = WAKE_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [3:0] CMD_EXEC_CYCLES = 4'h4;

  typedef struct packed {
    logic [2:0] chan;
    logic [3:0] first_led;
    logic [3:0] second_led;
    logic [3:0] third_led;
  } meas_req_s;

endpackage

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] addr = 0, wdata = 0, rev = 8'h08;
  logic wr = 0, rd = 0, irq_en = 0, fclr = 0, slow = 0;
  logic [5:0] list = 0;
  logic [2:0] ovf_chan = 3'h7;
  logic [7:0] rdata, param, v, d;
  logic start, done, ovf, stby, flag, irq;
  logic [2:0] sink;
  sensor_mailbox_pkg::meas_req_s req;
  integer seed = 92, miscompares = 0, cmp_count = 0, cyc = 0, nstart = 0;
  integer exp_resp = 0, pend = 0, lp = 0, l3 = 0;
  integer starts[$];
  logic [7:0] tbl [4] = '{8'h09, 8'h0F, 8'h10, 8'h17};

  always #20 clk = ~clk;

  sensor_command_response_mailbox #(
    .WAKE_UNIT_CYCLES(4),
    .EARLY_REVISION(8'h5A)
  ) i_sensor_command_response_mailbox (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .sequencer_revision_i(rev), .enabled_channel_list_i(list),
    .cmd_irq_enable_i(irq_en), .cmd_flag_clear_i(fclr),
    .meas_done_i(done), .meas_overflow_i(ovf), .meas_start_o(start),
    .meas_req_o(req), .led_sink_en_o(sink), .param_value_o(param),
    .standby_o(stby), .cmd_flag_o(flag), .irq_o(irq)
  );

  conv_model i_conv_model (
    .clk_i(clk), .start_i(start), .chan_i(req.chan),
    .ovf_chan_i(ovf_chan), .slow_i(slow), .done_o(done), .ovf_o(ovf)
  );

  task complete_run();
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] dv);
    @(negedge clk);
    addr = a;
    wdata = dv;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [7:0] dv);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    dv = rdata;
  endtask

  // host side: command completion is seen by polling the flag; a forced walk gets a fixed 100-cycle wait
  task cmd(input logic [7:0] c);
    logic drop;
    integer n;
    drop = exp_resp[7] && c > 8'h01;
    @(negedge clk);
    fclr = 1;
    irq_en = 1'($random(seed));
    @(negedge clk);
    fclr = 0;
    wr_reg(8'h18, c);
    if (drop) begin
      repeat (12) @(negedge clk);
      chk(flag, 0);
    end else begin
      chk(stby, 0);
      n = 0;
      while (flag !== 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
      end
      chk(flag, 1);
      @(negedge clk);
      chk(irq, irq_en);
      // a forced walk runs after the command completes; let it finish
      if (c == 8'h06) repeat (100) @(negedge clk);
      if (pend != 0) exp_resp = pend;
      else if (c == 8'h01 || (c == 8'h00 && exp_resp[7])) exp_resp = 0;
      else if (c inside {8'h00, 8'h06, 8'h0B, 8'h0F, 8'hA0})
        exp_resp = (exp_resp + 1) & 15;
      else exp_resp = 8'h80;
      pend = 0;
    end
    rd_reg(8'h20, d);
    chk(d, exp_resp[7:0]);
  endtask

  always @(negedge clk) begin
    if (start === 1'b1) begin
      nstart++;
      starts.push_back(cyc);
      chk(req.first_led, lp[3:0]);
      chk(req.second_led, lp[7:4]);
      chk(req.third_led, l3[3:0]);
    end
    if (done === 1'b1)
      chk(sink, req.chan < 3 ?
        {l3[3:0] != 0, lp[7:4] != 0, lp[3:0] != 0} : 3'h0);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    integer k, j;
    repeat (16) @(negedge clk);
    rst_n = 1;
    chk(stby, 1);
    for (k = 0; k < 4; k++) begin
      rd_reg(tbl[k], d);
      chk(d, 0);
    end
    wr_reg(8'h07, 8'h17);
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      wr_reg(tbl[k], v);
      if (k == 1) lp = v;
      if (k == 2) l3 = v & 15;
      rd_reg(tbl[k], d);
      chk(d, k == 2 ? v & 8'h0F : v);
    end
    wr_reg(8'h20, 8'h55);
    rd_reg(8'h20, d);
    chk(d, 0);
    chk(stby, 1);
    for (k = 0; k < 17; k++) cmd(8'h00);
    v = $random(seed);
    wr_reg(8'h17, v);
    cmd(8'hA0);
    chk(param, v);
    cmd(8'h37);
    cmd(8'h06);
    cmd(8'h00);
    cmd(8'h37);
    cmd(8'h01);
    for (k = 0; k < 6; k++) begin
      list = $random(seed) | (6'h01 << k);
      lp = $random(seed) & (k == 0 ? 8'h0F : 8'hFF);
      v = $random(seed);
      l3 = v & 15;
      wr_reg(8'h0F, lp[7:0]);
      wr_reg(8'h10, v);
      ovf_chan = k[2:0];
      slow = k[0];
      pend = k < 3 ? 8'h88 + k : 8'h8C + k - 3;
      nstart = 0;
      cmd(8'h06);
      chk(nstart, $countones(list));
      cmd(8'h00);
    end
    for (k = 0; k < 2; k++) begin
      rev = k ? 8'h5A : 8'h08;
      list = 6'h01;
      ovf_chan = 0;
      wr_reg(k ? 8'h0A : 8'h08, 8'h02);
      wr_reg(k ? 8'h08 : 8'h09, 8'h01);
      starts.delete();
      cmd(8'h0F);
      repeat (2300) @(negedge clk);
      rd_reg(8'h20, d);
      chk(d, 8'h88);
      chk(starts.size() > 1, 1);
      for (j = 1; j < starts.size(); j++)
        chk(starts[j] - starts[j - 1], 258 * 4);
      exp_resp = 8'h88;
      cmd(8'h01);
      starts.delete();
      repeat (1100) @(negedge clk);
      chk(starts.size(), 0);
    end
    cmd(8'h0F);
    cmd(8'h0B);
    starts.delete();
    repeat (1100) @(negedge clk);
    chk(starts.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire

//--- wake_timer.sv
`timescale 1ns/10ps
`default_nettype none
module wake_timer #(
  parameter int UNIT_CYCLES = sensor_mailbox_pkg::WAKE_UNIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [15:0] interval_i,
  output logic wake_o
);
  logic [31:0] unit_cnt_reg;
  logic [15:0] unit_tally_reg;
  logic unit_tick;

  assign unit_tick = (unit_cnt_reg == 32'(UNIT_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i || unit_tick) begin
      unit_cnt_reg <= 32'h0000_0000;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + 32'h0000_0001;
    end
  end

  // interval zero means no autonomous wake at all
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i || interval_i == 16'h0000) begin
      unit_tally_reg <= 16'h0000;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      if (unit_tick) begin
        if (unit_tally_reg >= interval_i - 16'h0001) begin
          unit_tally_reg <= 16'h0000;
          wake_o <= 1'b1; // R2
        end else begin
          unit_tally_reg <= unit_tally_reg + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire
